// ==== inc/pio_pkg.sv ====
// Purpose: shared constants for the programmable port block
// Assumes: single clock domain, synchronous active-high reset
// Notes: bit indices, mode codes and reset values live here
`default_nettype none

package pio_pkg;
    // ------------------------------------------------------------
    // port widths and reset values
    // ------------------------------------------------------------
    localparam int PIO_P1_W = 8;
    localparam logic [7:0] PIO_DIR_RST = 8'h00;
    localparam logic [7:0] PIO_LATCH_RST = 8'h00;
    localparam logic [3:0] PIO_DRV_RST = 4'h0;
    localparam logic [3:0] PIO_PULL_RST = 4'h0;
    localparam logic [7:0] PIO_P3_IMPL = 8'hb8;
    localparam logic [7:0] PIO_P4_IMPL = 8'h20;

    // ------------------------------------------------------------
    // pull-up group positions in the grouped select vector
    // ------------------------------------------------------------
    localparam int PIO_PU_P1LO = 0;
    localparam int PIO_PU_P1HI = 1;
    localparam int PIO_PU_P33 = 2;
    localparam int PIO_PU_P3GRP = 3;

    // ------------------------------------------------------------
    // mode and code values
    // ------------------------------------------------------------
    localparam logic [3:0] PIO_AN_BASE = 4'h9;
    localparam logic [1:0] PIO_TX_EVENT_MODE = 2'h1;
    localparam logic [1:0] PIO_TZ_PULSE_MODE = 2'h1;

    // uart0 transmit modes that own the transmit pin
    function automatic logic pio_uart_tx_mode(input logic [2:0] smd);
        return (smd == 3'h1) || (smd == 3'h4) || (smd == 3'h5) || (smd == 3'h6);
    endfunction
endpackage

`default_nettype wire

// ==== logic/pio_bit_cell.sv ====
// Purpose: one bidirectional port bit: latch, direction, pin drive
// Assumes: pin input already synchronous to I_CLK
// Notes: peripheral override takes the pin regardless of direction
`default_nettype none

module pio_bit_cell
    import pio_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wr_data,     // write strobe for data latch
    input wire logic i_wr_dir,      // write strobe for direction
    input wire logic i_wdata,       // write value
    input wire logic i_pin,         // sampled pin level
    input wire logic i_per_en,      // peripheral owns pin output
    input wire logic i_per_val,     // peripheral drive value
    input wire logic i_per_od,      // peripheral uses open drain
    output logic o_dir,
    output logic o_read,            // value seen on data read
    output logic o_drive,           // pin driver value
    output logic o_oe_n             // low while driving
);
    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    logic latch;
    wire logic drive_val;
    wire logic drive_on;

    // latch written whatever the direction
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            latch <= 1'b0;
            o_dir <= 1'b0;
        end else begin
            if (i_wr_data) latch <= i_wdata;
            if (i_wr_dir) o_dir <= i_wdata;
        end
    end

    // peripheral output wins over direction; open drain drives low only
    assign drive_val = i_per_en ? i_per_val : latch;
    assign drive_on = i_per_en ? (!i_per_od || !i_per_val) : o_dir;
    assign o_drive = drive_val;
    assign o_oe_n = !drive_on;
    // input mode reads pin, output mode reads latch
    assign o_read = o_dir ? latch : i_pin;
endmodule

`default_nettype wire

// ==== logic/pio_osc_pins.sv ====
// Purpose: oscillator pin pair control
// Assumes: clock-stop bits come from the clock controller
// Notes: the two pins are input-only when not assigned to the oscillator
`default_nettype none

module pio_osc_pins
    import pio_pkg::*;
(
    input wire logic i_osc_sel,
    input wire logic i_all_stop,
    input wire logic i_main_stop,
    input wire logic i_xin,
    input wire logic i_oscillator_out_pin,
    output logic o_buf_on,
    output logic o_fb_on,
    output logic o_oscillator_out_pin_high,
    output logic o_ext_clk_en,
    output logic [1:0] o_port_in
);
    // buffer only when assigned and both stops clear
    assign o_buf_on = i_osc_sel && !i_all_stop && !i_main_stop;
    assign o_fb_on = i_osc_sel && !i_all_stop;
    // external clock: buffer off, oscillator_out_pin held high
    assign o_ext_clk_en = i_osc_sel && !i_all_stop && i_main_stop;
    assign o_oscillator_out_pin_high = o_ext_clk_en;
    // plain inputs only when not assigned
    assign o_port_in = i_osc_sel ? 2'h0 : {i_oscillator_out_pin, i_xin};
endmodule

`default_nettype wire

// ==== logic/pio_top.sv ====
// Purpose: programmable port block with peripheral pin muxing
// Assumes: pins sampled synchronously; writes are one-cycle strobes
// Notes: outputs registered; pin enable outputs are active low
//
// Behaviour
// - thirteen bidirectional bits on ports one, three, four
// - oscillator pins are input only when unassigned
// - direction bit zero input, one output
// - read returns pin in input, latch in output
// - writes always update latch; driven in output
// - pull-ups only in input, grouped selection
// - port one bits 0-3 high drive select
// - unimplemented direction bits hold no state
// - peripheral outputs drive regardless of direction
// - analog inputs on matching channel code
// - compare output enable takes over pin
// - key inputs active low when enabled
// - timer z waveform on port one bit three
// - uart0 transmit on bit four, open drain option
// - uart0 receive and event alt on bit five
// - uart0 transfer clock on bit six
// - timer x event and interrupt zero on seven
// - i2c enable takes port three bits four, five
// - timer x inverted out on port three seven
// - oscillator select gates buffer and feedback
// - external clock mode holds output high
// - port four bit five feeds interrupt zero
`default_nettype none

module pio_top
    import pio_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET,
    // ------------- software access
    input wire logic i_wr_p1_data,
    input wire logic i_wr_p1_dir,
    input wire logic i_wr_p3_data,
    input wire logic i_wr_p3_dir,
    input wire logic i_wr_p4_data,
    input wire logic i_wr_p4_dir,
    input wire logic i_wr_pullup,
    input wire logic i_wr_drive,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_p1_read,
    output logic [7:0] o_p3_read,
    output logic [7:0] o_p4_read,
    output logic [7:0] o_p1_dir,
    output logic [7:0] o_p3_dir,
    output logic [7:0] o_p4_dir,
    // ------------- peripheral settings
    input wire logic [3:0] i_key_input_enable,
    input wire logic [5:0] i_compare_output_enable,
    input wire logic [5:0] i_compare_out,
    input wire logic [3:0] i_converter_channel_code,
    input wire logic [1:0] i_timer_z_mode_field,
    input wire logic i_timer_z_output_control,
    input wire logic i_timer_z_waveform,
    input wire logic [2:0] i_serial_mode_field,
    input wire logic i_clock_direction_bit,
    input wire logic i_open_drain_select,
    input wire logic i_uart0_tx,
    input wire logic i_uart0_clk_out,
    input wire logic i_counter_pin_select,
    input wire logic [1:0] i_timer_x_mode_field,
    input wire logic i_timer_x_output_control,
    input wire logic i_timer_x_inv,
    input wire logic [1:0] i_uart1_pin_select,
    input wire logic i_i2c_enable_bit,
    input wire logic i_sda_out,
    input wire logic i_scl_out,
    input wire logic i_ext_interrupt0_enable,
    input wire logic i_oscillator_pin_select,
    input wire logic i_all_clock_stop_bit,
    input wire logic i_main_clock_stop_bit,
    // ------------- pins (four signals per port, plus port one high drive and analog select)
    input wire logic [7:0] I_P1_IN,
    input wire logic [7:0] I_P3_IN,
    input wire logic [7:0] I_P4_IN,
    output logic [7:0] O_P1_OUT,
    output logic [7:0] O_P1_OE_N,
    output logic [7:0] O_P3_OUT,
    output logic [7:0] O_P3_OE_N,
    output logic [7:0] O_P4_OUT,
    output logic [7:0] O_P4_OE_N,
    output logic [7:0] O_P1_PULLUP,
    output logic [7:0] O_P3_PULLUP,
    output logic [7:0] O_P4_PULLUP,
    output logic [3:0] O_P1_HIGH_DRIVE,
    output logic [3:0] O_ANALOG_SEL,
    // ------------- peripheral inputs
    output logic [3:0] O_KEY_INPUT_N,
    output logic O_UART0_RX,
    output logic O_UART0_CLK_IN,
    output logic O_TIMER_X_EVENT,
    output logic O_EXT_EXT_INTERRUPT0_PIN_N,
    output logic O_EXT_INT1_N,
    output logic O_TIMER_C_IN,
    output logic O_SDA_IN,
    output logic O_SCL_IN,
    output logic O_OSC_BUF_ON,
    output logic O_OSC_FB_ON,
    output logic O_EXT_CLK_EN
);
    // --------------------------------------------------------
    // control registers
    // --------------------------------------------------------
    logic [3:0] pull_group;        // grouped pull-up select
    logic [3:0] drive_strength_select;
    logic [1:0] osc_in;            // oscillator pins as inputs

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            pull_group <= PIO_PULL_RST;
            drive_strength_select <= PIO_DRV_RST;
        end else begin
            if (i_wr_pullup) pull_group <= i_wdata[3:0];
            if (i_wr_drive) drive_strength_select <= i_wdata[3:0];
        end
    end

    // --------------------------------------------------------
    // peripheral output override per pin
    // --------------------------------------------------------
    wire logic tz_own = i_timer_z_mode_field[1] ||
        (i_timer_z_mode_field == PIO_TZ_PULSE_MODE && !i_timer_z_output_control);
    // mode 01b with control set: plain output port whatever the direction
    wire logic tz_port = (i_timer_z_mode_field == PIO_TZ_PULSE_MODE) &&
        i_timer_z_output_control;
    wire logic [7:0] p1_force = {4'h0, tz_port, 3'h0};
    wire logic tx_own = pio_uart_tx_mode(i_serial_mode_field);
    wire logic clk_own = !i_serial_mode_field[2] && i_serial_mode_field[0] &&
        !i_clock_direction_bit;
    wire logic tx_event = i_timer_x_mode_field == PIO_TX_EVENT_MODE;
    wire logic [7:0] p1_per_en = {1'b0, clk_own, 1'b0, tx_own, tz_own,
        i_compare_output_enable[2:0]};
    wire logic [7:0] p1_per_val = {1'b0, i_uart0_clk_out, 1'b0, i_uart0_tx,
        i_timer_z_waveform, i_compare_out[2:0]};
    wire logic [7:0] p1_per_od = {3'h0, i_open_drain_select, 4'h0};
    // i2c beats compare output on port three bits four, five
    wire logic [7:0] p3_per_en = {i_timer_x_output_control, 1'b0,
        i_i2c_enable_bit | i_compare_output_enable[5],
        i_i2c_enable_bit | i_compare_output_enable[4],
        i_compare_output_enable[3], 3'h0};
    wire logic [7:0] p3_per_val = {i_timer_x_inv, 1'b0,
        i_i2c_enable_bit ? i_scl_out : i_compare_out[5],
        i_i2c_enable_bit ? i_sda_out : i_compare_out[4],
        i_compare_out[3], 3'h0};
    wire logic [7:0] p3_per_od = {2'h0, {2{i_i2c_enable_bit}}, 4'h0};

    // --------------------------------------------------------
    // bit cells: only implemented bits have state
    // --------------------------------------------------------
    wire logic [7:0] p1_rd, p3_rd, p4_rd, p1_dv, p3_dv, p4_dv;
    wire logic [7:0] p1_oe, p3_oe, p4_oe, p1_dr, p3_dr, p4_dr;

    genvar g;
    generate
        for (g = 0; g < PIO_P1_W; g++) begin : g_bits
            pio_bit_cell u_p1 (
                .i_clk(I_CLK), .i_reset(I_RESET),
                .i_wr_data(i_wr_p1_data), .i_wr_dir(i_wr_p1_dir),
                .i_wdata(i_wdata[g]), .i_pin(I_P1_IN[g]),
                .i_per_en(p1_per_en[g]), .i_per_val(p1_per_val[g]),
                .i_per_od(p1_per_od[g]), .o_dir(p1_dr[g]), .o_read(p1_rd[g]),
                .o_drive(p1_dv[g]), .o_oe_n(p1_oe[g]));
            if (PIO_P3_IMPL[g]) begin : g_p3
                pio_bit_cell u_p3 (
                    .i_clk(I_CLK), .i_reset(I_RESET),
                    .i_wr_data(i_wr_p3_data), .i_wr_dir(i_wr_p3_dir),
                    .i_wdata(i_wdata[g]), .i_pin(I_P3_IN[g]),
                    .i_per_en(p3_per_en[g]), .i_per_val(p3_per_val[g]),
                    .i_per_od(p3_per_od[g]), .o_dir(p3_dr[g]), .o_read(p3_rd[g]),
                    .o_drive(p3_dv[g]), .o_oe_n(p3_oe[g]));
            end else begin : g_p3_none
                // input-only bit, direction reads zero
                assign p3_dr[g] = 1'b0;
                assign p3_rd[g] = I_P3_IN[g];
                assign p3_dv[g] = 1'b0;
                assign p3_oe[g] = 1'b1;
            end
            if (PIO_P4_IMPL[g]) begin : g_p4
                pio_bit_cell u_p4 (
                    .i_clk(I_CLK), .i_reset(I_RESET),
                    .i_wr_data(i_wr_p4_data), .i_wr_dir(i_wr_p4_dir),
                    .i_wdata(i_wdata[g]), .i_pin(I_P4_IN[g]),
                    .i_per_en(1'b0), .i_per_val(1'b0), .i_per_od(1'b0),
                    .o_dir(p4_dr[g]), .o_read(p4_rd[g]),
                    .o_drive(p4_dv[g]), .o_oe_n(p4_oe[g]));
            end else begin : g_p4_none
                assign p4_dr[g] = 1'b0;
                // split so no bit ever indexes osc_in out of range
                if (g >= 6) begin : g_osc
                    assign p4_rd[g] = osc_in[g - 6];
                end else begin : g_plain
                    assign p4_rd[g] = I_P4_IN[g];
                end
                assign p4_dv[g] = 1'b0;
                assign p4_oe[g] = 1'b1;
            end
        end
    endgenerate

    // --------------------------------------------------------
    // oscillator pins
    // --------------------------------------------------------
    wire logic osc_buf, osc_fb, osc_xhi, osc_ext;
    pio_osc_pins u_osc (
        .i_osc_sel(i_oscillator_pin_select), .i_all_stop(i_all_clock_stop_bit),
        .i_main_stop(i_main_clock_stop_bit), .i_xin(I_P4_IN[6]),
        .i_oscillator_out_pin(I_P4_IN[7]), .o_buf_on(osc_buf), .o_fb_on(osc_fb),
        .o_oscillator_out_pin_high(osc_xhi), .o_ext_clk_en(osc_ext), .o_port_in(osc_in));

    // --------------------------------------------------------
    // pull-up expansion: input mode and no override only
    // --------------------------------------------------------
    wire logic [7:0] p1_pu_grp = {{4{pull_group[PIO_PU_P1HI]}}, {4{pull_group[PIO_PU_P1LO]}}};
    wire logic [7:0] p3_pu_grp = {pull_group[PIO_PU_P3GRP], 1'b0,
        {2{pull_group[PIO_PU_P3GRP]}}, pull_group[PIO_PU_P33], 3'h0};
    wire logic [7:0] p4_pu_grp = {2'h0, pull_group[PIO_PU_P33], 5'h0};
    wire logic [3:0] analog_sel;
    for (g = 0; g < 4; g++) begin : g_an
        // channel codes 1001b, 1011b, 1101b, 1111b
        assign analog_sel[g] = (i_converter_channel_code ==
            PIO_AN_BASE + 4'(2 * g)) && !p1_dr[g] && !p1_pu_grp[g];
    end
    wire logic [7:0] p1_pu = p1_pu_grp & ~p1_dr & ~p1_per_en & ~p1_force;
    wire logic [7:0] p3_pu = p3_pu_grp & ~p3_dr & ~p3_per_en;
    wire logic [7:0] p4_pu = p4_pu_grp & ~p4_dr;
    wire logic p1_in_nopu [8];
    for (g = 0; g < 8; g++) begin : g_np
        assign p1_in_nopu[g] = !p1_dr[g] && !p1_pu_grp[g];
    end

    // --------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            {o_p1_read, o_p3_read, o_p4_read} <= 24'h0;
            {o_p1_dir, o_p3_dir, o_p4_dir} <= 24'h0;
            {O_P1_OUT, O_P3_OUT, O_P4_OUT} <= 24'h0;
            {O_P1_OE_N, O_P3_OE_N, O_P4_OE_N} <= 24'hffffff;
            {O_P1_PULLUP, O_P3_PULLUP, O_P4_PULLUP} <= 24'h0;
            O_P1_HIGH_DRIVE <= 4'h0;
            O_ANALOG_SEL <= 4'h0;
            O_KEY_INPUT_N <= 4'hf;
            {O_UART0_RX, O_UART0_CLK_IN, O_TIMER_X_EVENT} <= 3'h7;
            {O_EXT_EXT_INTERRUPT0_PIN_N, O_EXT_INT1_N, O_TIMER_C_IN} <= 3'h7;
            {O_SDA_IN, O_SCL_IN} <= 2'h3;
            {O_OSC_BUF_ON, O_OSC_FB_ON, O_EXT_CLK_EN} <= 3'h0;
        end else begin
            o_p1_read <= p1_rd;
            o_p3_read <= p3_rd;
            o_p4_read <= p4_rd;
            o_p1_dir <= p1_dr;
            o_p3_dir <= p3_dr;
            o_p4_dir <= p4_dr;
            O_P1_OUT <= p1_dv;
            O_P1_OE_N <= p1_oe & ~p1_force;
            O_P3_OUT <= p3_dv;
            O_P3_OE_N <= p3_oe;
            // oscillator_out_pin driven high in external clock mode
            O_P4_OUT <= {osc_xhi, p4_dv[6:0]};
            O_P4_OE_N <= {!osc_xhi, p4_oe[6:0]};
            O_P1_PULLUP <= p1_pu;
            O_P3_PULLUP <= p3_pu;
            O_P4_PULLUP <= p4_pu;
            O_P1_HIGH_DRIVE <= drive_strength_select & (p1_dr[3:0] | p1_force[3:0]);
            O_ANALOG_SEL <= analog_sel;
            // key input idles high when not selected
            for (int k = 0; k < 4; k++) begin
                O_KEY_INPUT_N[k] <= (i_key_input_enable[k] && p1_in_nopu[k]) ?
                    I_P1_IN[k] : 1'b1;
            end
            O_UART0_RX <= (!p1_dr[5] && !tx_event) ? I_P1_IN[5] : 1'b1;
            O_UART0_CLK_IN <= (i_clock_direction_bit && !p1_dr[6]) ?
                I_P1_IN[6] : 1'b1;
            O_TIMER_X_EVENT <= tx_event ? 1'b1 : (i_counter_pin_select ?
                (p1_dr[5] ? 1'b1 : I_P1_IN[5]) :
                (p1_in_nopu[7] ? I_P1_IN[7] : 1'b1));
            O_EXT_INT1_N <= (i_counter_pin_select && !p1_dr[5] && !tx_event) ?
                I_P1_IN[5] : 1'b1;
            // interrupt zero from port four bit five or port one bit seven
            O_EXT_EXT_INTERRUPT0_PIN_N <= (i_ext_interrupt0_enable && !p4_dr[5] && !p4_pu_grp[5]) ?
                I_P4_IN[5] : ((!i_counter_pin_select && p1_in_nopu[7] && !tx_event) ?
                I_P1_IN[7] : 1'b1);
            O_TIMER_C_IN <= (!p3_dr[3] && !i_compare_output_enable[3]) ?
                I_P3_IN[3] : 1'b1;
            O_SDA_IN <= i_i2c_enable_bit ? I_P3_IN[4] : 1'b1;
            O_SCL_IN <= i_i2c_enable_bit ? I_P3_IN[5] : 1'b1;
            O_OSC_BUF_ON <= osc_buf;
            O_OSC_FB_ON <= osc_fb;
            O_EXT_CLK_EN <= osc_ext;
        end
    end

    // --------------------------------------------------------
    // checks
    // --------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    sequence s_dir_out(int b); i_wr_p1_dir && i_wdata[0] && b == 0; endsequence
    read_latch_a: assert property (p1_dr[0] && !p1_per_en[0] |=>
        o_p1_read[0] == O_P1_OUT[0])
        else $error("read not latch");
    out_drive_a: assert property (s_dir_out(0) ##1 !p1_per_en[0] |=> !O_P1_OE_N[0])
        else $error("pin not driven in output");
    pullup_in_a: assert property (O_P1_PULLUP[0] |-> $past(!p1_dr[0]))
        else $error("pullup on output pin");
    cmp_take_a: assert property (i_compare_output_enable[0] |=> O_P1_OUT[0] ==
        $past(i_compare_out[0]) && !O_P1_OE_N[0])
        else $error("compare output not on pin");
    i2c_own_a: assert property (i_i2c_enable_bit && !i_sda_out |=> !O_P3_OE_N[4])
        else $error("i2c not driving");
    unimpl_dir_a: assert property (o_p3_dir[0] == 1'b0 && o_p4_dir[7] == 1'b0)
        else $error("unimplemented direction");
    osc_buf_a: assert property (!i_oscillator_pin_select |=> !O_OSC_BUF_ON)
        else $error("buffer on while port");
    oscillator_out_pin_high_a: assert property (osc_ext |=> O_P4_OUT[7] && !O_OSC_BUF_ON)
        else $error("oscillator_out_pin not high");
    key_idle_a: assert property (!i_key_input_enable[0] |=> O_KEY_INPUT_N[0])
        else $error("key input active");
    tx_pin_a: assert property (tx_own && !i_open_drain_select |=> !O_P1_OE_N[4])
        else $error("transmit not driven");
endmodule

`default_nettype wire

// ==== dv/pio_pin_model.sv ====
// Purpose: far-side pin model, resolves one 8-bit port wire level
// Assumes: released pins show the pull-up or the far-side level
// Notes: no keeper; a released pin never holds the driven value
`default_nettype none

module pio_pin_model (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe_n,
    input wire logic [7:0] i_pullup,
    input wire logic [7:0] i_ext,
    output logic [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // driver wins, then pull-up, then whatever the board puts there
    assign o_pin = (~i_oe_n & i_out) | (i_oe_n & (i_pullup | i_ext));
endmodule

`default_nettype wire

// ==== dv/programmable_io_port_block_tb_top.sv ====
// Purpose: self-checking bench for the port block
// Assumes: inputs change on the falling edge only
// Notes: waits four cycles after a change; outputs settle in two
`default_nettype none

module programmable_io_port_block_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic I_CLK = 0, I_RESET = 1;
    logic [7:0] strobes = 0, i_wdata = 0, ext1 = 0, ext3 = 0, ext4 = 0;
    wire logic i_wr_p1_data, i_wr_p1_dir, i_wr_p3_data, i_wr_p3_dir;
    wire logic i_wr_p4_data, i_wr_p4_dir, i_wr_pullup, i_wr_drive;
    logic [3:0] i_key_input_enable = 0, i_converter_channel_code = 0;
    logic [5:0] i_compare_output_enable = 0, i_compare_out = 0;
    logic [1:0] i_timer_z_mode_field = 0, i_timer_x_mode_field = 0, i_uart1_pin_select = 0;
    logic [2:0] i_serial_mode_field = 0;
    logic i_timer_z_output_control = 0, i_timer_z_waveform = 0, i_clock_direction_bit = 0;
    logic i_open_drain_select = 0, i_uart0_tx = 1, i_uart0_clk_out = 0;
    logic i_counter_pin_select = 0, i_timer_x_output_control = 0, i_timer_x_inv = 0;
    logic i_i2c_enable_bit = 0, i_sda_out = 1, i_scl_out = 1, i_ext_interrupt0_enable = 0;
    logic i_oscillator_pin_select = 0, i_all_clock_stop_bit = 0, i_main_clock_stop_bit = 0;
    wire logic [7:0] I_P1_IN, I_P3_IN, I_P4_IN;
    logic [7:0] o_p1_read, o_p3_read, o_p4_read, o_p1_dir, o_p3_dir, o_p4_dir;
    logic [7:0] O_P1_OUT, O_P1_OE_N, O_P3_OUT, O_P3_OE_N, O_P4_OUT, O_P4_OE_N;
    logic [7:0] O_P1_PULLUP, O_P3_PULLUP, O_P4_PULLUP;
    logic [3:0] O_P1_HIGH_DRIVE, O_ANALOG_SEL, O_KEY_INPUT_N;
    logic O_UART0_RX, O_UART0_CLK_IN, O_TIMER_X_EVENT, O_EXT_EXT_INTERRUPT0_PIN_N, O_EXT_INT1_N;
    logic O_TIMER_C_IN, O_SDA_IN, O_SCL_IN, O_OSC_BUF_ON, O_OSC_FB_ON, O_EXT_CLK_EN;
    int err_count = 0, cmp_count = 0;
    // rows: dir, data, far-side level, read, oe_n
    logic [39:0] rows [4] = '{40'h00ffa5a5ff, 40'hff3c003c00, 40'h0faa555af0, 40'hf011ee1e0f};

    // one-hot strobe vector, one bit per write port
    assign {i_wr_drive, i_wr_pullup, i_wr_p4_dir, i_wr_p4_data, i_wr_p3_dir, i_wr_p3_data,
        i_wr_p1_dir, i_wr_p1_data} = strobes;
    always #4ns I_CLK = ~I_CLK;

    pio_top dut (.*);
    pio_pin_model pm1 (.i_out(O_P1_OUT), .i_oe_n(O_P1_OE_N), .i_pullup(O_P1_PULLUP),
        .i_ext(ext1), .o_pin(I_P1_IN));
    pio_pin_model pm3 (.i_out(O_P3_OUT), .i_oe_n(O_P3_OE_N), .i_pullup(O_P3_PULLUP),
        .i_ext(ext3), .o_pin(I_P3_IN));
    pio_pin_model pm4 (.i_out(O_P4_OUT), .i_oe_n(O_P4_OE_N), .i_pullup(O_P4_PULLUP),
        .i_ext(ext4), .o_pin(I_P4_IN));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // a blank edge first, so back-to-back writes never re-drive a strobe at once
    task automatic wr(input logic [7:0] s, input logic [7:0] d);
        @(negedge I_CLK);
        strobes = s;
        i_wdata = d;
        @(negedge I_CLK);
        strobes = 8'h00;
    endtask
    // cell plus output register is two edges; four leaves margin
    task automatic settle;
        repeat (4) @(negedge I_CLK);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic done(input string n);
        $display("test %s done", n);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge I_CLK);
        I_RESET = 0;
        settle;
        chk("dir", 8'h00, o_p1_dir | o_p3_dir | o_p4_dir);
        chk("oe_n", 8'hff, O_P1_OE_N & O_P3_OE_N & O_P4_OE_N);
        chk("pullup", 8'h00, O_P1_PULLUP | {4'h0, O_P1_HIGH_DRIVE});
        done("reset");
        // data before direction: latch loads under the previous row's direction
        for (int i = 0; i < 4; i++) begin
            ext1 = rows[i][23:16];
            wr(8'h01, rows[i][31:24]);
            wr(8'h02, rows[i][39:32]);
            settle;
            chk("p1_read", rows[i][15:8], o_p1_read);
            chk("p1_oe_n", rows[i][7:0], O_P1_OE_N);
            chk("p1_out", rows[i][31:24] & rows[i][39:32], O_P1_OUT & rows[i][39:32]);
        end
        done("rows");
        ext3 = 8'h47;
        wr(8'h08, 8'hff);
        wr(8'h20, 8'hff);
        settle;
        chk("p3_dir", 8'hb8, o_p3_dir);
        chk("p4_dir", 8'h20, o_p4_dir);
        chk("p3_read", 8'h47, o_p3_read & 8'h47);
        wr(8'h40, 8'h0f);
        settle;
        chk("p1_pullup", 8'h0f, O_P1_PULLUP);
        chk("p4_pullup", 8'h00, O_P4_PULLUP);
        wr(8'h20, 8'h00);
        wr(8'h02, 8'hff);
        wr(8'h80, 8'h05);
        settle;
        chk("p4_pullup", 8'h20, O_P4_PULLUP);
        chk("p1_pullup", 8'h00, O_P1_PULLUP);
        chk("high_drive", 8'h05, {4'h0, O_P1_HIGH_DRIVE});
        done("control");
        // all port one inputs, no pull-ups, far-side levels low on ports one and four, high on port three
        wr(8'h02, 8'h00);
        wr(8'h40, 8'h00);
        ext1 = 8'h00;
        ext3 = 8'hff;
        ext4 = 8'h00;
        i_key_input_enable = 4'h2;
        i_converter_channel_code = 4'hb;
        i_compare_output_enable = 6'h01;
        i_compare_out = 6'h01;
        i_ext_interrupt0_enable = 1;
        i_timer_x_output_control = 1;
        i_timer_x_inv = 1;
        i_i2c_enable_bit = 1;
        i_sda_out = 0;
        settle;
        chk("key_n", 8'h0d, {4'h0, O_KEY_INPUT_N});
        chk("analog", 8'h02, {4'h0, O_ANALOG_SEL});
        chk("cmp_pin", 8'h01, {O_P1_OE_N[0], O_P1_OUT[0]});
        chk("rx_ev_int", 8'h00, {O_UART0_RX, O_TIMER_X_EVENT, O_EXT_EXT_INTERRUPT0_PIN_N});
        chk("cntr_pin", 8'h01, {O_P3_OE_N[7], O_P3_OUT[7]});
        chk("i2c_oe_n", 8'h02, {O_P3_OE_N[5], O_P3_OE_N[4]});
        chk("i2c_in", 8'h01, {O_SDA_IN, O_SCL_IN});
        i_timer_x_mode_field = 2'h1;
        i_serial_mode_field = 3'h1;
        i_uart0_tx = 0;
        i_uart0_clk_out = 1;
        i_timer_z_mode_field = 2'h2;
        i_timer_z_waveform = 1;
        settle;
        chk("event_off", 8'h01, {7'h00, O_TIMER_X_EVENT});
        chk("uart_pins", 8'h02, {O_P1_OE_N[6], O_P1_OE_N[4], O_P1_OUT[6], O_P1_OUT[4]});
        chk("tz_pin", 8'h01, {O_P1_OE_N[3], O_P1_OUT[3]});
        i_open_drain_select = 1;
        i_uart0_tx = 1;
        i_timer_z_mode_field = 2'h1;
        i_timer_z_output_control = 1;
        settle;
        chk("od_tx", 8'h01, {7'h00, O_P1_OE_N[4]});
        chk("tz_port", 8'h00, {7'h00, O_P1_OE_N[3]});
        done("peripherals");
        // counter pin on bit five, external transfer clock, port three bit three input
        i_counter_pin_select = 1;
        i_clock_direction_bit = 1;
        i_timer_x_mode_field = 2'h0;
        ext3 = 8'h00;
        wr(8'h08, 8'h00);
        settle;
        chk("ext_in", 8'h00, {4'h0, O_UART0_CLK_IN, O_EXT_INT1_N, O_TIMER_X_EVENT, O_TIMER_C_IN});
        done("inputs");
        chk("osc_off", 8'h00, {O_OSC_BUF_ON, O_OSC_FB_ON, O_EXT_CLK_EN});
        i_oscillator_pin_select = 1;
        settle;
        chk("osc_run", 8'h06, {O_OSC_BUF_ON, O_OSC_FB_ON, O_EXT_CLK_EN});
        i_main_clock_stop_bit = 1;
        settle;
        chk("osc_ext", 8'h03, {O_OSC_BUF_ON, O_OSC_FB_ON, O_EXT_CLK_EN});
        chk("oscillator_out_pin_pin", 8'h02, {5'h00, O_P4_OE_N[7], O_P4_OUT[7], o_p4_read[7]});
        done("oscillator");
        summarize();
    end

    // hang guard: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge I_CLK);
        err_count++;
        summarize();
    end
endmodule

`default_nettype wire
